// ===== omap_device.sv
// Device end: register windows into EEPROM, SRAM and ROM, program unlock,
// commit of live registers into an SRAM page, and crystal cap readback.
// Assumes the host holds req until ack and frames transactions cleanly.
`timescale 1ns/100ps

module omap_device #(
  parameter int PROG_CYCLES = omap_pkg::PROG_CYCLES,
  parameter int PAGE_BYTES = omap_pkg::PAGE_BYTES
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Link
  omap_link_if.dev link,
  // Live configuration and straps
  input wire logic [9:0] xo_cap_setting,
  input wire logic [1:0] boot_page_pins,
  input wire logic [PAGE_BYTES*8-1:0] live_cfg,
  // Status
  output logic [1:0] default_page,
  output logic prog_busy,
  output logic prog_invalid
);

  localparam int MEM_DEPTH = 1 << omap_pkg::MEM_AW;
  localparam int CIDX_W = $clog2(PAGE_BYTES);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0] cur_addr_reg;          // Link register address
  logic [11:0] win_idx_reg;          // Steps taken inside a window
  logic [11:0] mem_ptr_reg;          // Memory pointer
  logic [7:0] key_reg;               // Program unlock key
  logic [3:0] page_reg;              // Commit page field
  logic key_seen_reg;                // Key written in this transaction
  logic key_armed_reg;               // Key written in the previous one
  logic busy_reg;                    // Erase/program running
  logic [omap_pkg::PROG_CNT_W-1:0] prog_cnt_reg;
  logic invalid_reg;                 // Last program cycle was spoiled
  logic commit_run_reg;              // Register to SRAM copy running
  logic [CIDX_W-1:0] commit_idx_reg; // Byte being copied
  logic boot_done_reg;               // Strap sampled
  logic [1:0] default_page_reg;      // Page picked by the straps
  logic ack_reg;
  logic [7:0] rdata_reg;
  logic [7:0] eeprom_mem [MEM_DEPTH];
  logic [7:0] sram_mem [MEM_DEPTH];

  // Stand-in ROM contents, a fixed function of the address
  function automatic logic [7:0] rom_byte(input logic [11:0] a);
    return a[7:0] ^ {a[11:8], a[11:8]};
  endfunction

  // ----------------------------------------------------------------
  // Access decode
  // ----------------------------------------------------------------
  // One access per request; the ack cycle blocks a double take
  wire acc = link.req & ~ack_reg & ~link.txn_begin;
  wire acc_wr = acc & link.req_wr;
  wire is_ctl = (cur_addr_reg == omap_pkg::REG_CTL);
  wire is_ee = (cur_addr_reg == omap_pkg::REG_EE_WIN);
  wire is_sram = (cur_addr_reg == omap_pkg::REG_SRAM_WIN);
  wire is_rom = (cur_addr_reg == omap_pkg::REG_ROM_WIN);
  wire in_win = is_ee | is_sram | is_rom;
  // Window address: pointer plus steps already taken
  wire [11:0] win_addr = 12'(mem_ptr_reg + win_idx_reg);
  wire [omap_pkg::MEM_AW-1:0] mem_addr = win_addr[omap_pkg::MEM_AW-1:0];
  // EEPROM window is read-only and closed while programming
  wire ee_stall = is_ee & (link.req_wr | busy_reg);
  wire win_step = acc & in_win & ~ee_stall;
  wire key_ok = (link.req_wdata == omap_pkg::UNLOCK_KEY);
  wire wr_key = acc_wr & (cur_addr_reg == omap_pkg::REG_KEY);
  wire wr_ctl = acc_wr & is_ctl;
  wire prog_start = wr_ctl & link.req_wdata[omap_pkg::CTL_PROG_BIT] & key_armed_reg
    & ~busy_reg & ~commit_run_reg;
  // Pages above the last valid one are not committed
  wire commit_start = wr_ctl & link.req_wdata[omap_pkg::CTL_COMMIT_BIT] & ~commit_run_reg
    & ~busy_reg & (page_reg <= omap_pkg::PAGE_LAST);
  wire prog_done = busy_reg & (prog_cnt_reg == omap_pkg::PROG_CNT_W'(PROG_CYCLES - 1));
  wire prog_abort = busy_reg & link.foreign_pkt;
  wire commit_last = commit_run_reg & (commit_idx_reg == CIDX_W'(PAGE_BYTES - 1));
  wire [omap_pkg::MEM_AW-1:0] commit_addr =
    omap_pkg::MEM_AW'(page_reg * PAGE_BYTES + commit_idx_reg);
  wire [7:0] commit_byte = live_cfg[commit_idx_reg*8 +: 8];
  wire sram_link_wr = acc_wr & is_sram;

  // Read data by current register address
  logic [7:0] rd_val;
  always_comb begin
    case (cur_addr_reg)
      omap_pkg::REG_CTL: begin
        rd_val = 8'h00;
        rd_val[omap_pkg::CTL_BUSY_BIT] = busy_reg;
        rd_val[omap_pkg::CTL_COMMIT_BIT] = commit_run_reg;
      end
      omap_pkg::REG_PTR_HI: rd_val = {4'h0, mem_ptr_reg[11:8]};
      omap_pkg::REG_PTR_LO: rd_val = mem_ptr_reg[7:0];
      // Denied reads return zero while programming
      omap_pkg::REG_EE_WIN: rd_val = busy_reg ? 8'h00 : eeprom_mem[mem_addr];
      omap_pkg::REG_SRAM_WIN: rd_val = sram_mem[mem_addr];
      omap_pkg::REG_ROM_WIN: rd_val = rom_byte(win_addr);
      omap_pkg::REG_KEY: rd_val = key_reg;
      omap_pkg::REG_PAGE: rd_val = {4'h0, page_reg};
      omap_pkg::REG_XO_HI: rd_val = {6'h00, xo_cap_setting[9:8]};
      omap_pkg::REG_XO_LO: rd_val = xo_cap_setting[7:0];
      default: rd_val = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // Link answer
  // ----------------------------------------------------------------
  assign link.ack = ack_reg;
  assign link.ack_rdata = rdata_reg;

  // Answer one cycle after the request is taken
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ack_reg <= 1'b0;
      rdata_reg <= 8'h00;
    end else begin
      ack_reg <= acc;
      if (acc && !link.req_wr) begin
        rdata_reg <= rd_val;
      end
    end
  end

  // ----------------------------------------------------------------
  // Address walk and window lock
  // ----------------------------------------------------------------
  // Outside a window the address steps; inside it stays put
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cur_addr_reg <= 8'h00;
      win_idx_reg <= 12'h000;
    end else if (link.txn_begin) begin
      // A new transaction releases any window lock
      cur_addr_reg <= link.txn_addr;
      win_idx_reg <= 12'h000;
    end else if (acc && !in_win) begin
      cur_addr_reg <= cur_addr_reg + 8'h01;
    end else if (win_step) begin
      win_idx_reg <= win_idx_reg + 12'h001;
    end
  end

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      mem_ptr_reg <= omap_pkg::RST_PTR;
      key_reg <= omap_pkg::RST_KEY;
      page_reg <= omap_pkg::RST_PAGE;
    end else if (acc_wr) begin
      case (cur_addr_reg)
        omap_pkg::REG_PTR_HI: mem_ptr_reg[11:8] <= link.req_wdata[3:0];
        omap_pkg::REG_PTR_LO: mem_ptr_reg[7:0] <= link.req_wdata;
        omap_pkg::REG_KEY: key_reg <= link.req_wdata;
        omap_pkg::REG_PAGE: page_reg <= link.req_wdata[3:0];
        default: ;
      endcase
    end
  end

  // Unlock tracking: only the transaction just before counts
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      key_seen_reg <= 1'b0;
      key_armed_reg <= 1'b0;
    end else if (link.txn_begin) begin
      key_armed_reg <= key_seen_reg;
      key_seen_reg <= 1'b0;
    end else if (wr_key) begin
      key_seen_reg <= key_ok;
    end
  end

  // ----------------------------------------------------------------
  // Erase/program cycle
  // ----------------------------------------------------------------
  // Start bit is never stored, so it reads back as zero
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      busy_reg <= 1'b0;
      prog_cnt_reg <= '0;
      invalid_reg <= 1'b0;
    end else if (prog_start) begin
      busy_reg <= 1'b1;
      prog_cnt_reg <= '0;
      invalid_reg <= 1'b0;
    end else if (prog_abort) begin
      busy_reg <= 1'b0;
      invalid_reg <= 1'b1;
    end else if (prog_done) begin
      busy_reg <= 1'b0;
    end else if (busy_reg) begin
      prog_cnt_reg <= prog_cnt_reg + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Register to SRAM copy, one byte per cycle
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      commit_run_reg <= 1'b0;
      commit_idx_reg <= '0;
    end else if (commit_start) begin
      commit_run_reg <= 1'b1;
      commit_idx_reg <= '0;
    end else if (commit_run_reg) begin
      commit_idx_reg <= commit_idx_reg + 1'b1;
      if (commit_last) begin
        commit_run_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Storage, one process per entry
  // ----------------------------------------------------------------
  // The copy wins over a link write to the same byte
  for (genvar i = 0; i < MEM_DEPTH; i++) begin : g_mem
    always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
        sram_mem[i] <= 8'h00;
      end else if (commit_run_reg && commit_addr == i) begin
        sram_mem[i] <= commit_byte;
      end else if (sram_link_wr && mem_addr == i) begin
        sram_mem[i] <= link.req_wdata;
      end
    end
    // EEPROM takes the whole SRAM image when programming completes
    always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
        eeprom_mem[i] <= 8'h00;
      end else if (prog_done && !prog_abort) begin
        eeprom_mem[i] <= sram_mem[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // Default page from the straps, caught once after reset release
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      boot_done_reg <= 1'b0;
      default_page_reg <= 2'b00;
    end else if (!boot_done_reg) begin
      boot_done_reg <= 1'b1;
      default_page_reg <= boot_page_pins;
    end
  end

  assign default_page = default_page_reg;
  assign prog_busy = busy_reg;
  assign prog_invalid = invalid_reg;

endmodule

// ===== omap_host.sv
// Host end: turns APB orders into link transactions and byte accesses.
// Assumes software polls the status word before issuing the next order.
`timescale 1ns/100ps
module omap_host (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Guard: device erase/program running
  input wire logic prog_guard,
  // Link
  omap_link_if.host link
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic open_reg;        // Transaction open
  logic busy_reg;        // Byte access outstanding
  logic req_reg;         // Request to device
  logic wr_reg;          // Direction of outstanding access
  logic [7:0] wdata_reg; // Write byte
  logic [7:0] rdata_reg; // Last read byte
  logic begin_reg;       // Begin pulse
  logic end_reg;         // End pulse
  logic foreign_reg;     // Foreign packet pulse
  logic [7:0] addr_reg;  // Start address

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  wire access = psel & penable;
  wire wr_en = access & pwrite;
  wire hit_ctl = (paddr == omap_pkg::HOST_CTL_OFS);
  wire hit_wr = (paddr == omap_pkg::HOST_WR_OFS);
  wire hit_rd = (paddr == omap_pkg::HOST_RD_OFS);
  wire hit_stat = (paddr == omap_pkg::HOST_STAT_OFS);
  wire mapped = hit_ctl | hit_wr | hit_rd | hit_stat;
  wire idle_open = open_reg & ~busy_reg;
  // Orders that would break a byte access in flight are dropped; a foreign packet is also dropped while a transaction is open
  wire do_begin = wr_en & hit_ctl & pwdata[omap_pkg::HCTL_BEGIN_BIT] & ~busy_reg;
  wire do_finish = wr_en & hit_ctl & pwdata[omap_pkg::HCTL_FINISH_BIT] & idle_open;
  // Other devices must stay silent while the device programs
  wire do_foreign = wr_en & hit_ctl & pwdata[omap_pkg::HCTL_FOREIGN_BIT] & ~open_reg
    & ~prog_guard;
  wire do_byte = wr_en & (hit_wr | hit_rd) & idle_open;
  wire [31:0] stat_word = {16'h0000, rdata_reg, 6'h00, open_reg, busy_reg};

  // Zero wait states; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = access & ~mapped;
  assign prdata = (access & ~pwrite & hit_stat) ? stat_word : 32'h0000_0000;

  // ----------------------------------------------------------------
  // Link drive
  // ----------------------------------------------------------------
  assign link.txn_begin = begin_reg;
  assign link.txn_addr = addr_reg;
  assign link.txn_end = end_reg;
  assign link.foreign_pkt = foreign_reg;
  assign link.req = req_reg;
  assign link.req_wr = wr_reg;
  assign link.req_wdata = wdata_reg;

  // Transaction framing pulses
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      begin_reg <= 1'b0;
      end_reg <= 1'b0;
      foreign_reg <= 1'b0;
      addr_reg <= 8'h00;
      open_reg <= 1'b0;
    end else begin
      begin_reg <= do_begin;
      end_reg <= do_finish;
      foreign_reg <= do_foreign;
      if (do_begin) begin
        addr_reg <= pwdata[omap_pkg::HCTL_ADDR_LSB +: 8];
      end
      if (do_begin) begin
        open_reg <= 1'b1;
      end else if (do_finish) begin
        open_reg <= 1'b0;
      end
    end
  end

  // Byte access: request held until the device acknowledges
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      busy_reg <= 1'b0;
      req_reg <= 1'b0;
      wr_reg <= 1'b0;
      wdata_reg <= 8'h00;
      rdata_reg <= 8'h00;
    end else if (do_byte) begin
      busy_reg <= 1'b1;
      req_reg <= 1'b1;
      wr_reg <= hit_wr;
      wdata_reg <= pwdata[7:0];
    end else if (req_reg && link.ack) begin
      busy_reg <= 1'b0;
      req_reg <= 1'b0;
      if (!wr_reg) begin
        rdata_reg <= link.ack_rdata;
      end
    end
  end

endmodule

// ===== omap_link_if.sv
// Transaction-level link between the host controller and the device.
// Assumes both ends run on the same clock; the bench joins them here.
`timescale 1ns/100ps
interface omap_link_if;
  logic txn_begin;       // Pulse: transaction opens at txn_addr
  logic [7:0] txn_addr;  // Register address sent at transaction start
  logic txn_end;         // Pulse: transaction closes
  logic foreign_pkt;     // Pulse: packet to another device on the bus
  logic req;             // Byte access request, held until ack
  logic req_wr;          // 1 = write byte, 0 = read byte
  logic [7:0] req_wdata; // Write byte
  logic ack;             // Pulse: byte access done
  logic [7:0] ack_rdata; // Read byte, valid with ack

  modport dev (
    input txn_begin, txn_addr, txn_end, foreign_pkt, req, req_wr, req_wdata,
    output ack, ack_rdata
  );
  modport host (
    output txn_begin, txn_addr, txn_end, foreign_pkt, req, req_wr, req_wdata,
    input ack, ack_rdata
  );
endinterface

// ===== omap_pkg.sv
// Shared constants for the on-chip memory access port and its host end.
// Assumes a single 200 MHz clock shared by both ends of the link.
package omap_pkg;

  // ----------------------------------------------------------------
  // Device register addresses on the link
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTL = 8'h89;      // Memory control register
  localparam logic [7:0] REG_PTR_HI = 8'h8B;   // Memory pointer, bits 11:8
  localparam logic [7:0] REG_PTR_LO = 8'h8C;   // Memory pointer, bits 7:0
  localparam logic [7:0] REG_EE_WIN = 8'h8D;   // EEPROM read window
  localparam logic [7:0] REG_SRAM_WIN = 8'h8E; // SRAM access window
  localparam logic [7:0] REG_ROM_WIN = 8'h8F;  // ROM read window
  localparam logic [7:0] REG_KEY = 8'h90;      // Program unlock key
  localparam logic [7:0] REG_PAGE = 8'h91;     // Commit page select
  localparam logic [7:0] REG_XO_HI = 8'hC7;    // Crystal cap readback high
  localparam logic [7:0] REG_XO_LO = 8'hC8;    // Crystal cap readback low

  // ----------------------------------------------------------------
  // Fields and values
  // ----------------------------------------------------------------
  localparam int CTL_PROG_BIT = 0;             // Program start, self-clearing
  localparam int CTL_BUSY_BIT = 2;             // Program in progress
  localparam int CTL_COMMIT_BIT = 6;           // Register to SRAM copy
  localparam logic [7:0] UNLOCK_KEY = 8'hEA;   // Only key that unlocks
  localparam logic [3:0] PAGE_LAST = 4'h5;     // Highest valid page
  localparam int NUM_PAGES = 6;                // Configuration pages
  localparam int MEM_AW = 9;                   // EEPROM and SRAM address bits
  localparam int PTR_W = 12;                   // Pointer and ROM address bits
  localparam int PAGE_BYTES = 16;              // Bytes copied per page
  localparam logic [7:0] RST_KEY = 8'h00;
  localparam logic [3:0] RST_PAGE = 4'h0;
  localparam logic [11:0] RST_PTR = 12'h000;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 5;            // 200 MHz
  localparam int PROG_TIME_US = 230000;        // Erase/program time, 230 ms
  localparam int PROG_CYCLES = PROG_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int PROG_CNT_W = 26;              // Counter width for the above

  // ----------------------------------------------------------------
  // Host APB register map
  // ----------------------------------------------------------------
  localparam logic [7:0] HOST_CTL_OFS = 8'h00;  // Begin, finish, foreign
  localparam logic [7:0] HOST_WR_OFS = 8'h04;   // Write one byte
  localparam logic [7:0] HOST_RD_OFS = 8'h08;   // Read one byte
  localparam logic [7:0] HOST_STAT_OFS = 8'h0C; // Status and read data
  localparam int HCTL_BEGIN_BIT = 0;
  localparam int HCTL_FINISH_BIT = 1;
  localparam int HCTL_FOREIGN_BIT = 2;
  localparam int HCTL_ADDR_LSB = 8;
  localparam int HSTAT_BUSY_BIT = 0;
  localparam int HSTAT_OPEN_BIT = 1;
  localparam int HSTAT_DATA_LSB = 8;

endpackage

// ===== omap_sva.sv
// Checker for the link between the host and device ends of the port.
// Assumes the bench wires it beside the link interface, on one clock.
`timescale 1ns/100ps
module omap_sva #(
  parameter int PROG_CYCLES = 20
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Link signals
  input wire logic txn_begin,
  input wire logic txn_end,
  input wire logic foreign_pkt,
  input wire logic req,
  input wire logic req_wr,
  input wire logic ack,
  // Device status
  input wire logic prog_busy,
  input wire logic prog_invalid
);
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  localparam int BUSY_MAX = PROG_CYCLES + 4; // Slack for start and stop edges
  logic open_reg; // A transaction is framed
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // Follow the framing so byte requests can be judged against it
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      open_reg <= 1'b0;
    end else if (txn_begin) begin
      open_reg <= 1'b1;
    end else if (txn_end) begin
      open_reg <= 1'b0;
    end
  end
  sequence s_waiting;
    req && !ack && !txn_begin;
  endsequence
  sequence s_write_seen;
    $past(req && req_wr, 1) || $past(req && req_wr, 2) || $past(req && req_wr, 3);
  endsequence
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  a_ack_next_cycle: assert property (s_waiting |=> ack)
    else $error("Byte access not answered in one cycle");
  a_ack_one_pulse: assert property (ack |=> !ack)
    else $error("Answer held too long");
  a_ack_has_cause: assert property (ack |-> $past(req))
    else $error("Answer without request");
  a_req_held_wait: assert property (req && !ack |=> req)
    else $error("Request dropped before answer");
  a_req_drop_ack: assert property (ack |=> !req)
    else $error("Request kept after answer");
  a_req_in_frame: assert property (req |-> open_reg)
    else $error("Byte request outside a transaction");
  a_busy_ends_bound: assert property ($rose(prog_busy) |-> ##[1:BUSY_MAX] !prog_busy)
    else $error("Program cycle too long");
  a_busy_from_write: assert property ($rose(prog_busy) |-> s_write_seen)
    else $error("Program started without a write");
  a_abort_stops_busy: assert property (prog_busy && foreign_pkt |-> ##[1:2] !prog_busy)
    else $error("Foreign packet did not stop program");
  a_invalid_cause: assert property ($rose(prog_invalid) |-> $past(foreign_pkt, 1)
    || $past(foreign_pkt, 2))
    else $error("Invalid flag without foreign packet");
endmodule

// ===== omap_tb.sv
// Bench joining host and device ends of the memory access port.
// Assumes 200 MHz and a shortened erase/program time.
`timescale 1ns/100ps
module onchip_memory_access_port_tb;
  // ------------------------------------------------------------
  // Wiring
  // ------------------------------------------------------------
  localparam int PROG = 200; // Short program time, still longer than a few orders
  logic ref_clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
  logic guard_on; // Opened only by the abort test
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, stat, rd;
  logic [9:0] xo_cap_setting = 10'h2A5;
  logic [1:0] boot_page_pins = 2'h2;
  logic [1:0] default_page;
  logic [127:0] live_cfg;
  logic prog_busy, prog_invalid;
  int fails, compares;
  omap_link_if i_omap_link_if();
  omap_host i_omap_host(.ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .prog_guard(prog_busy & guard_on), .link(i_omap_link_if.host));
  omap_device #(.PROG_CYCLES(PROG)) i_omap_device(.ref_clk, .rst_n,
    .link(i_omap_link_if.dev), .xo_cap_setting, .boot_page_pins, .live_cfg, .default_page,
    .prog_busy, .prog_invalid);
  omap_sva #(.PROG_CYCLES(PROG)) i_omap_sva(.ref_clk, .rst_n,
    .txn_begin(i_omap_link_if.txn_begin), .txn_end(i_omap_link_if.txn_end),
    .foreign_pkt(i_omap_link_if.foreign_pkt), .req(i_omap_link_if.req),
    .req_wr(i_omap_link_if.req_wr), .ack(i_omap_link_if.ack), .prog_busy, .prog_invalid);
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("Counts: %0d compares, %0d fails", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    rd = prdata;
    err = pslverr;
    if (pready !== 1'b1) begin
      fails++;
      report_and_stop();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  // Poll status until the host has finished its order
  task automatic idle;
    int n;
    n = 0;
    do begin
      apb(1'b0, omap_pkg::HOST_STAT_OFS, 32'h0);
      stat = rd;
      n++;
    end while (stat[omap_pkg::HSTAT_BUSY_BIT] !== 1'b0 && n < 40);
    if (stat[omap_pkg::HSTAT_BUSY_BIT] !== 1'b0) begin
      fails++;
      report_and_stop();
    end
  endtask
  task automatic ctl(input logic [31:0] d);
    apb(1'b1, omap_pkg::HOST_CTL_OFS, d);
    idle();
  endtask
  task automatic put(input logic [7:0] b);
    apb(1'b1, omap_pkg::HOST_WR_OFS, {24'h0, b});
    idle();
  endtask
  // Read one byte; it lands in stat[15:8]
  task automatic get;
    apb(1'b1, omap_pkg::HOST_RD_OFS, 32'h0);
    idle();
  endtask
  // Write n bytes, low byte first, in one transaction
  task automatic wtx(input logic [7:0] a, input int n, input logic [31:0] b);
    ctl({16'h0, a, 8'h01});
    for (int i = 0; i < n; i++) begin
      put(b[8*i +: 8]);
    end
    ctl(32'h2);
  endtask
  task automatic rtx(input logic [7:0] a, input int n, input logic [31:0] b);
    ctl({16'h0, a, 8'h01});
    for (int i = 0; i < n; i++) begin
      get();
      chk(stat[15:8], b[8*i +: 8]);
    end
    ctl(32'h2);
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_sram;
    wtx(omap_pkg::REG_PTR_HI, 2, 32'h020F);
    wtx(omap_pkg::REG_SRAM_WIN, 3, 32'hC3B2A1);
    rtx(omap_pkg::REG_SRAM_WIN, 3, 32'hC3B2A1);
    $display("t_sram done");
  endtask
  task automatic t_rom;
    wtx(omap_pkg::REG_PTR_HI, 2, 32'hBC0A);
    rtx(omap_pkg::REG_ROM_WIN, 3, 32'h141716);
    $display("t_rom done");
  endtask
  task automatic t_xo;
    rtx(omap_pkg::REG_XO_HI, 2, 32'hA502);
    apb(1'b0, 8'h10, 32'h0);
    chk(err, 1'b1);
    $display("t_xo done");
  endtask
  task automatic t_prog;
    wtx(omap_pkg::REG_KEY, 1, 32'hEA);
    wtx(omap_pkg::REG_CTL, 1, 32'h01);
    chk(prog_busy, 1'b1);
    ctl(32'h4);
    chk(prog_busy, 1'b1);
    for (int n = 0; n < 400 && prog_busy !== 1'b0; n++) begin
      @(posedge ref_clk);
    end
    chk({prog_busy, prog_invalid}, 2'b00);
    // A program cycle that never ends is a hang: stop here
    if (prog_busy !== 1'b0) begin
      report_and_stop();
    end
    // Pointer then EEPROM window reached by auto-increment
    ctl({16'h0, omap_pkg::REG_PTR_HI, 8'h01});
    put(8'h01);
    put(8'h02);
    for (int i = 0; i < 3; i++) begin
      get();
      chk(stat[15:8], 8'hA1 + 8'(8'h11 * i));
    end
    ctl(32'h2);
    $display("t_prog done");
  endtask
  task automatic t_refuse;
    wtx(omap_pkg::REG_KEY, 1, 32'hEA);
    wtx(omap_pkg::REG_PAGE, 1, 32'h01);
    wtx(omap_pkg::REG_CTL, 1, 32'h01);
    chk(prog_busy, 1'b0);
    wtx(omap_pkg::REG_KEY, 1, 32'hEB);
    wtx(omap_pkg::REG_CTL, 1, 32'h01);
    chk(prog_busy, 1'b0);
    $display("t_refuse done");
  endtask
  task automatic t_abort;
    wtx(omap_pkg::REG_KEY, 1, 32'hEA);
    wtx(omap_pkg::REG_CTL, 1, 32'h01);
    // Pointer still at the programmed bytes: reads are denied while busy
    rtx(omap_pkg::REG_EE_WIN, 1, 32'h0);
    guard_on <= 1'b0;
    ctl(32'h4);
    chk({prog_busy, prog_invalid}, 2'b01);
    guard_on <= 1'b1;
    $display("t_abort done");
  endtask
  task automatic t_commit;
    wtx(omap_pkg::REG_CTL, 1, 32'h40);
    repeat (omap_pkg::PAGE_BYTES + 4) @(posedge ref_clk);
    wtx(omap_pkg::REG_PTR_HI, 2, 32'h1000);
    rtx(omap_pkg::REG_SRAM_WIN, 3, 32'h323130);
    $display("t_commit done");
  endtask
  initial begin
    fails = 0;
    compares = 0;
    {psel, penable, pwrite, paddr, pwdata, rst_n} = '0;
    guard_on = 1'b1;
    for (int k = 0; k < 16; k++) begin
      live_cfg[8*k +: 8] = 8'h30 + 8'(k);
    end
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk(default_page, boot_page_pins);
    t_sram();
    t_rom();
    t_xo();
    t_prog();
    t_refuse();
    t_abort();
    t_commit();
    report_and_stop();
  end
endmodule
